// *** verilog/pots_top.sv ***
// Power-on test indicator sequencer with reset generation
`timescale 1ns/1ps
`default_nettype none

module pots_top #(
    parameter int unsigned FLASH_CYC = pots_pkg::FLASH_MS * pots_pkg::CYC_PER_MS,
    parameter int unsigned BIT_CYC   = pots_pkg::BIT_TEST_S * 1000 * pots_pkg::CYC_PER_MS,
    // Whole-second times scale with the bit test, so one override shortens them all
    parameter int unsigned ROM_CYC   = BIT_CYC / pots_pkg::BIT_TEST_S * pots_pkg::ROM_TEST_S,
    parameter int unsigned CLR_CYC   = BIT_CYC / pots_pkg::BIT_TEST_S * pots_pkg::CLEAR_S,
    parameter int unsigned FAIL_CYC  = BIT_CYC / pots_pkg::BIT_TEST_S * pots_pkg::FAIL_HOLD_S,
    parameter int unsigned KEY_CYC   = pots_pkg::KEY_LIMIT_MIN * 60_000 * pots_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // Reset sources
    input  wire logic               manual_reset_button_i,
    input  wire logic               supply_good_i,
    // Test progress from the processor
    input  wire pots_pkg::pots_fail_t fail_i,
    input  wire logic               keys_active_i,
    // Indicators and system reset
    output logic                    sys_rst_n_o,
    output pots_pkg::pots_led_t     leds_o,
    output logic                    keyboard_fault_o
);
    import pots_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Reset generation

    logic        rst_req;
    logic [31:0] hold_cnt;

    // A supply dip seen at a rising clk_i edge still yields a full-width reset pulse
    assign rst_req = manual_reset_button_i || !supply_good_i; // RL1 RL3

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hold_cnt <= 32'h0;
        end else if (rst_req) begin
            hold_cnt <= RST_HOLD_CYC;
        end else if (hold_cnt != 32'h0) begin
            hold_cnt <= hold_cnt - 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sys_rst_n_o <= 1'b0;
        end else begin
            sys_rst_n_o <= !rst_req && (hold_cnt == 32'h0); // RL1 RL3
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Step table

    function automatic logic [7:0] step_code(input logic [3:0] idx);
        case (idx)
            4'h0:    step_code = CODE_LED_ACK;
            4'h1:    step_code = CODE_ALL_ON;
            4'h2:    step_code = CODE_ALL_OFF;
            4'h3:    step_code = CODE_CPU;
            4'h4:    step_code = CODE_BOOT_SUM;
            4'h5:    step_code = CODE_DSP_ACK;
            4'h6:    step_code = CODE_DSP;
            4'h7:    step_code = CODE_MEM_ACK;
            4'h8:    step_code = CODE_MEM_SIZE;
            4'h9:    step_code = CODE_MEM_BIT;
            4'ha:    step_code = CODE_MEM_REF;
            4'hb:    step_code = CODE_PROG_ROM;
            default: step_code = CODE_ALL_OFF;
        endcase
    endfunction : step_code

    function automatic logic [31:0] step_len(input logic [3:0] idx);
        case (idx)
            4'h1, 4'h2: step_len = FLASH_CYC;            // RL10
            4'h9, 4'ha: step_len = BIT_CYC;              // RL14
            4'hb:       step_len = ROM_CYC;              // RL15
            4'hc:       step_len = CLR_CYC;              // RL15
            default:    step_len = BRIEF_CYC;            // RL16
        endcase
    endfunction : step_len

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    pots_state_t state;
    logic [3:0]  step_idx;
    logic [31:0] tmr;
    logic [7:0]  fail_code;
    logic        step_end;

    assign step_end = (tmr == step_len(step_idx) - 32'h1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_RESET;
        end else if (!sys_rst_n_o) begin
            state <= ST_RESET; // RL19
        end else begin
            case (state)
                ST_RESET: begin
                    state <= ST_LAMP; // RL5
                end
                ST_LAMP: begin
                    if (tmr == LAMP_CYC - 32'h1) begin
                        state <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    if (fail_i.fail) begin
                        state <= ST_FAIL; // RL17
                    end else if (step_end && step_idx == STEP_LAST) begin
                        state <= ST_DONE;
                    end
                end
                ST_FAIL: begin
                    // The pause ends and the run carries on at the next step
                    if (tmr == FAIL_CYC - 32'h1) begin
                        state <= (step_idx == STEP_LAST) ? ST_DONE : ST_STEP;
                    end
                end
                ST_DONE: begin
                    state <= ST_DONE;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !sys_rst_n_o) begin
            step_idx <= 4'h0; // RL19
        end else if (state == ST_STEP && !fail_i.fail && step_end
                     && step_idx != STEP_LAST) begin
            step_idx <= step_idx + 4'h1; // RL11 RL12 RL13 RL14 RL15
        end else if (state == ST_FAIL && tmr == FAIL_CYC - 32'h1
                     && step_idx != STEP_LAST) begin
            step_idx <= step_idx + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !sys_rst_n_o) begin
            tmr <= 32'h0;
        end else if (state == ST_RESET) begin
            tmr <= 32'h0;
        end else if (state == ST_LAMP && tmr == LAMP_CYC - 32'h1) begin
            tmr <= 32'h0;
        end else if (state == ST_STEP && (fail_i.fail || step_end)) begin
            tmr <= 32'h0;
        end else if (state == ST_FAIL && tmr == FAIL_CYC - 32'h1) begin
            tmr <= 32'h0;
        end else if (state != ST_DONE) begin
            tmr <= tmr + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fail_code <= LED_CODE_RST;
        end else if (state == ST_STEP && fail_i.fail) begin
            fail_code <= fail_i.code; // RL17
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Indicator drive

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            leds_o.supply <= SUPPLY_RST;
            leds_o.run    <= 1'b0;
            leds_o.code   <= LED_CODE_RST;
        end else begin
            leds_o.supply <= 1'b1; // RL6
            leds_o.run    <= (state != ST_RESET); // RL7
            case (state)
                ST_LAMP: leds_o.code <= CODE_ALL_ON; // RL5
                ST_STEP: leds_o.code <= step_code(step_idx); // RL8 RL9
                ST_FAIL: leds_o.code <= fail_code; // RL17
                default: leds_o.code <= CODE_ALL_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Keyboard start-up watchdog

    logic [31:0] key_cnt;
    logic        keys_seen;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !sys_rst_n_o) begin
            keys_seen <= 1'b0;
        end else if (keys_active_i) begin
            keys_seen <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !sys_rst_n_o) begin
            key_cnt <= 32'h0;
        end else if (!keys_seen && key_cnt != KEY_CYC) begin
            key_cnt <= key_cnt + 32'h1;
        end
    end

    // Sticky until the next system reset; a late keyboard does not clear it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !sys_rst_n_o) begin
            keyboard_fault_o <= 1'b0;
        end else if (!keys_seen && !keys_active_i
                     && key_cnt == KEY_CYC - 32'h1) begin
            keyboard_fault_o <= 1'b1; // RL18
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    btn_reset_a: assert property ( // RL1
        manual_reset_button_i |=> !sys_rst_n_o ##1 !sys_rst_n_o
    ) else $error("button did not hold system reset low");

    supply_reset_a: assert property ( // RL3
        !supply_good_i |=> (!sys_rst_n_o) [*2]
    ) else $error("supply dip did not give system reset");

    supply_led_a: assert property ( // RL6
        $past(rst_n_i) |-> leds_o.supply
    ) else $error("supply indicator went dark");

    lamp_test_a: assert property ( // RL5
        $rose(sys_rst_n_o) |-> ##2 (leds_o.code == CODE_ALL_ON && leds_o.run)
    ) else $error("lamp test missing after reset release");

    first_code_a: assert property ( // RL9
        (state == ST_LAMP && tmr == LAMP_CYC - 32'h1 && sys_rst_n_o)
        |=> ##1 leds_o.code == CODE_LED_ACK
    ) else $error("first step code wrong");

    step_order_a: assert property ( // RL11
        (sys_rst_n_o && $past(sys_rst_n_o) && $changed(step_idx))
        |-> step_idx == $past(step_idx) + 4'h1
    ) else $error("step index skipped or went back");

    brief_step_a: assert property ( // RL16
        (state == ST_STEP && step_idx == 4'h3) |-> tmr < BRIEF_CYC
    ) else $error("brief step ran too long");

    fail_hold_a: assert property ( // RL17
        (state == ST_STEP && fail_i.fail && sys_rst_n_o)
        ##1 sys_rst_n_o [*3]
        |-> ##0 (leds_o.code == $past(fail_i.code, 3) && state == ST_FAIL)
    ) else $error("fail code not held");

    key_fault_a: assert property ( // RL18
        (key_cnt == KEY_CYC - 32'h1 && !keys_seen && !keys_active_i
         && sys_rst_n_o) |=> keyboard_fault_o
    ) else $error("keyboard fault not raised");

    restart_a: assert property ( // RL19
        !sys_rst_n_o |=> (step_idx == 4'h0 && state == ST_RESET)
    ) else $error("sequence did not restart at reset");

    pass_run_c: cover property (state == ST_DONE);
    fail_run_c: cover property (state == ST_FAIL);
    key_fault_c: cover property ($rose(keyboard_fault_o));

endmodule : pots_top

`default_nettype wire

// *** verilog/pots_pkg.sv ***
// Constants and types for the power-on test indicator sequencer
//
// Behaviour
// RL1 - Holding the manual reset button drives the system reset output low.
// RL2 - Power supply keeps supply_good high while its outputs are valid.
// RL3 - Any low on supply_good, however short, drives system reset low; the logic samples it only at rising clk_i edges.
// RL4 - Reference board supplies the 80 MHz reference clock elsewhere.
// RL5 - All indicator LEDs light briefly when the reset button is released.
// RL6 - Supply indicator LED stays lit whenever the board has power.
// RL7 - Run indicator LED turns on as soon as reset is released.
// RL8 - Eight code LEDs show each step code in binary, MSB highest.
// RL9 - Pass sequence starts with code 0x08, the LED acknowledge test.
// RL10 - Then all code LEDs on for 200 ms, off for 200 ms.
// RL11 - Then 0x13 for processor board test, 0x14 for ROM checksum.
// RL12 - Then 0x0a for display acknowledge test, 0x10 for display test.
// RL13 - Then 0x01 memory acknowledge test, 0x17 memory size test.
// RL14 - Then 0x18 and 0x19, three seconds each.
// RL15 - Then 0x1c for five seconds, then zero for four seconds.
// RL16 - Steps without stated duration show only briefly.
// RL17 - A failure pauses the sequence and holds a fail code ten seconds.
// RL18 - Keyboard must become active within three minutes, else fault.
// RL19 - Sequence restarts from its first step at each reset release.
package pots_pkg;

    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

    // Short display and reset hold times, in microseconds
    localparam int unsigned BRIEF_US    = 100;
    localparam int unsigned LAMP_US     = 100;
    localparam int unsigned RST_HOLD_US = 10;
    localparam int unsigned BRIEF_CYC    = BRIEF_US * CYC_PER_US;
    localparam int unsigned LAMP_CYC     = LAMP_US * CYC_PER_US;
    localparam int unsigned RST_HOLD_CYC = RST_HOLD_US * CYC_PER_US;

    // Long display and keyboard watchdog times in their own units
    localparam int unsigned FLASH_MS      = 200;
    localparam int unsigned BIT_TEST_S    = 3;
    localparam int unsigned ROM_TEST_S    = 5;
    localparam int unsigned CLEAR_S       = 4;
    localparam int unsigned FAIL_HOLD_S   = 10;
    localparam int unsigned KEY_LIMIT_MIN = 3;

    // Step codes
    localparam logic [7:0] CODE_LED_ACK  = 8'h08;
    localparam logic [7:0] CODE_ALL_ON   = 8'hff;
    localparam logic [7:0] CODE_ALL_OFF  = 8'h00;
    localparam logic [7:0] CODE_CPU      = 8'h13;
    localparam logic [7:0] CODE_BOOT_SUM = 8'h14;
    localparam logic [7:0] CODE_DSP_ACK  = 8'h0a;
    localparam logic [7:0] CODE_DSP      = 8'h10;
    localparam logic [7:0] CODE_MEM_ACK  = 8'h01;
    localparam logic [7:0] CODE_MEM_SIZE = 8'h17;
    localparam logic [7:0] CODE_MEM_BIT  = 8'h18;
    localparam logic [7:0] CODE_MEM_REF  = 8'h19;
    localparam logic [7:0] CODE_PROG_ROM = 8'h1c;

    localparam logic [3:0] STEP_LAST = 4'hc;

    // Values after reset
    localparam logic [7:0] LED_CODE_RST = 8'h00;
    localparam logic       SUPPLY_RST   = 1'b1;

    typedef struct packed {
        logic       supply;
        logic       run;
        logic [7:0] code;
    } pots_led_t;

    typedef struct packed {
        logic       fail;
        logic [7:0] code;
    } pots_fail_t;

    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_LAMP  = 5'b00010,
        ST_STEP  = 5'b00100,
        ST_FAIL  = 5'b01000,
        ST_DONE  = 5'b10000
    } pots_state_t;

endpackage : pots_pkg

// *** bench/pots_partner.sv ***
// Model of the supply, reset button and reference clock of the board
`timescale 1ns/1ps
`default_nettype none

module pots_partner (
    // Board clock
    input  wire logic clk_i,
    // Board sources
    output logic      manual_reset_button_o,
    output logic      supply_good_o,
    output logic      ref_clk_o
);

    initial begin
        manual_reset_button_o = 1'b0;
        supply_good_o         = 1'b1;
        ref_clk_o             = 1'b0;
    end

    // Reference runs free, unrelated in phase to clk_i
    always #6.25 ref_clk_o = ~ref_clk_o;

    task automatic press(input logic down);
        @(posedge clk_i);
        #5 manual_reset_button_o = down;
    endtask : press

    // One-cycle dropout, the shortest glitch the board can see
    task automatic dip();
        @(posedge clk_i);
        #5 supply_good_o = 1'b0;
        @(posedge clk_i);
        #5 supply_good_o = 1'b1;
    endtask : dip

endmodule : pots_partner
`default_nettype wire

// *** bench/pots_top_tb_top.sv ***
// Self-checking bench for the power-on test indicator sequencer
`timescale 1ns/1ps
`default_nettype none

module pots_top_tb_top;
    import pots_pkg::*;

    localparam int FL = 40;
    localparam int BT = 60;
    localparam int RM = BT / 3 * 5;
    localparam int FC = BT / 3 * 10;
    localparam int KY = 9000;
    localparam logic [7:0] SEQ [14] = '{8'hff, 8'h08, 8'hff, 8'h00, 8'h13, 8'h14, 8'h0a,
                                       8'h10, 8'h01, 8'h17, 8'h18, 8'h19, 8'h1c, 8'h00};
    localparam int DUR [14] = '{LAMP_CYC, BRIEF_CYC, FL, FL, BRIEF_CYC, BRIEF_CYC, BRIEF_CYC,
                               BRIEF_CYC, BRIEF_CYC, BRIEF_CYC, BT, BT, RM, 0};

    typedef struct { logic [7:0] code; int dur; } pots_note_t;

    logic       clk_i         = 1'b0;
    logic       rst_n_i       = 1'b0;
    logic       keys_active_i = 1'b0;
    pots_fail_t fail_i        = '0;
    logic       button;
    logic       supply_good;
    logic       ref_clk;
    logic       sys_rst_n_o;
    logic       keyboard_fault_o;
    pots_led_t  leds_o;
    pots_note_t q[$];
    pots_note_t n;
    logic [7:0] cur = 8'h00;
    logic [7:0] fc;
    int         cnt = 0;
    int         prev_dur = 0;
    int         up_cnt = 0;
    int         fail_count = 0;
    int         checks = 0;

    always #50 clk_i = ~clk_i;

    pots_partner pots_partner_i (.clk_i(clk_i), .manual_reset_button_o(button),
                                 .supply_good_o(supply_good), .ref_clk_o(ref_clk));

    pots_top #(.FLASH_CYC(FL), .BIT_CYC(BT), .KEY_CYC(KY)) pots_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .manual_reset_button_i(button),
        .supply_good_i(supply_good), .fail_i(fail_i), .keys_active_i(keys_active_i),
        .sys_rst_n_o(sys_rst_n_o), .leds_o(leds_o), .keyboard_fault_o(keyboard_fault_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Pass sequence; a failure during 13 gives it no fixed length
    task automatic push_seq(input logic f);
        for (int i = 0; i < 14; i++) begin
            q.push_back('{SEQ[i], (f && i == 4) ? 0 : DUR[i]});
            if (f && i == 4) q.push_back('{fc, FC});
        end
    endtask : push_seq

    // Drop the notes of a run that a reset cuts short
    task automatic cut_run();
        q.delete();
        prev_dur = 0;
        q.push_back('{8'h00, 0});
    endtask : cut_run

    task automatic wait_code(input logic [7:0] c);
        for (int k = 0; k < 20000 && leds_o.code !== c; k++) @(negedge clk_i);
        check(leds_o.code, c);
        #1;
    endtask : wait_code

    // Monitor: each code change closes the last note and opens the next
    always @(negedge clk_i) begin
        up_cnt = sys_rst_n_o ? up_cnt + 1 : 0;
        if (leds_o.code !== cur) begin
            if (prev_dur != 0) check(cnt, prev_dur);
            if (q.size() == 0) begin
                check(leds_o.code, cur);
                prev_dur = 0;
            end else begin
                n = q.pop_front();
                check(leds_o.code, n.code);
                prev_dur = n.dur;
            end
            cur = leds_o.code;
            cnt = 1;
        end else begin
            cnt++;
        end
    end

    initial begin
        #(100 * 60000);
        fail_count++;
        summarize();
    end

    initial begin
        void'($urandom(21395));
        fc = 8'h80 | 8'($urandom % 127);
        push_seq(1'b0);
        repeat (6) @(posedge clk_i);
        #5;
        check(sys_rst_n_o, 1'b0);
        check(leds_o.supply, 1'b1);
        check(leds_o.run, 1'b0);
        rst_n_i = 1'b1;
        wait_code(8'hff);
        check(leds_o.run, 1'b1);
        check(leds_o.supply, 1'b1);
        wait_code(8'h1c);
        while (up_cnt < KY - 3) @(negedge clk_i);
        check(keyboard_fault_o, 1'b0);
        repeat (6) @(negedge clk_i);
        check(keyboard_fault_o, 1'b1);
        $display("test pass_and_watchdog done");
        pots_partner_i.press(1'b1);
        // Button is sampled at the first edge after the press, and reset drops on that same edge
        repeat (2) @(negedge clk_i);
        check(sys_rst_n_o, 1'b0);
        push_seq(1'b1);
        repeat ($urandom % 50) @(posedge clk_i);
        pots_partner_i.press(1'b0);
        repeat (50) @(negedge clk_i);
        check(sys_rst_n_o, 1'b0);
        check(keyboard_fault_o, 1'b0);
        wait_code(8'h13);
        repeat ($urandom % 300) @(posedge clk_i);
        #5 fail_i = '{1'b1, fc};
        keys_active_i = 1'b1;
        @(posedge clk_i);
        #5 fail_i = '0;
        keys_active_i = 1'b0;
        wait_code(8'h1c);
        while (up_cnt < KY + 3) @(negedge clk_i);
        check(keyboard_fault_o, 1'b0);
        $display("test fail_hold done");
        pots_partner_i.press(1'b1);
        push_seq(1'b0);
        pots_partner_i.press(1'b0);
        wait_code(8'h13);
        cut_run();
        pots_partner_i.press(1'b1);
        repeat (2) @(negedge clk_i);
        check(sys_rst_n_o, 1'b0);
        push_seq(1'b0);
        pots_partner_i.press(1'b0);
        wait_code(8'h17);
        cut_run();
        pots_partner_i.dip();
        @(negedge clk_i);
        check(sys_rst_n_o, 1'b0);
        check(leds_o.supply, 1'b1);
        push_seq(1'b0);
        wait_code(8'h1c);
        $display("test restarts done");
        summarize();
    end

endmodule : pots_top_tb_top
`default_nettype wire
